// ==== hw/ssal_top.sv ====
// Purpose: Synchronous serial audio link, APB slave, tx and rx
// Assumes: i_pclk_en is the power manager clock gate
// Notes: Bit clocks sampled on mclk; words up to 32 bits, LSB first
// Functional notes
// - Receiver and transmitter run apart and share one divider.
// - Each direction has data, bit clock and frame sync lines.
// - Each direction starts automatically or on a frame sync event.
// - One DMA request per direction moves words up to 32 bits.
// - Rx data is input, tx data output, clocks and syncs two-way.
// - The interrupt is high while a pending flag is unmasked.
// - Each source has its own mask bit.
// - A status register shows which event is pending.
// - Registers and flags hold and both engines drop to idle while the peripheral clock gate is off.
// - The divider uses a 12-bit N, zero off, mclk over 2N.
// - Tx free sets on load to shifter, tx empty when both empty.
// - Rx copies full shifter to holding, sets flag, overrun overwrites.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ssal_cfg.svh"
module ssal_top
  import ssal_pkg::*;
(
  // Clock, reset, gate
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_pclk_en,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Receive pins
  input wire logic i_rx_serial_in,
  input wire logic i_rx_bit_clock,
  output logic o_rx_bit_clock,
  output logic o_rx_bit_clock_oe,
  input wire logic i_rx_frame_sync,
  output logic o_rx_frame_sync,
  output logic o_rx_frame_sync_oe,
  // Transmit pins
  output logic o_tx_serial_out,
  input wire logic i_tx_bit_clock,
  output logic o_tx_bit_clock,
  output logic o_tx_bit_clock_oe,
  input wire logic i_tx_frame_sync,
  output logic o_tx_frame_sync,
  output logic o_tx_frame_sync_oe,
  // DMA requests
  output logic o_dma_tx_req,
  output logic o_dma_rx_req,
  // Interrupt
  output logic o_irq
);
  ////////////////////////////////////////////////////////////////////
  // Registers and pin synchronisers
  logic [1:0] ctrl;
  logic [`SSAL_DIV_W-1:0] div;
  logic [15:0] txmode;
  logic [15:0] rxmode;
  ssal_word_type thr;
  ssal_word_type rhr;
  logic [`SSAL_NEVT-1:0] stat;
  logic [`SSAL_NEVT-1:0] mask;
  logic thr_full;
  logic [2:0] s_rk;
  logic [2:0] s_tk;
  logic [2:0] s_rf;
  logic [2:0] s_tf;
  logic [2:0] s_rd;
  logic rk_q;
  logic tk_q;
  logic rf_q;
  logic tf_q;
  logic rd_q;
  logic dclk;
  logic drise;
  logic dfall;
  // Agreed level: change once second and third stages agree
  function automatic logic agree(input logic [2:0] s, input logic prev);
    agree = (s[1] == s[2]) ? s[1] : prev;
  endfunction : agree
  ssal_div u_div (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_div(div),
    .o_clk(dclk),
    .o_rise(drise),
    .o_fall(dfall)
  );
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      s_rk <= '0;
      s_tk <= '0;
      s_rf <= '0;
      s_tf <= '0;
      s_rd <= '0;
      rk_q <= 1'b0;
      tk_q <= 1'b0;
      rf_q <= 1'b0;
      tf_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      s_rk <= {s_rk[1:0], i_rx_bit_clock};
      s_tk <= {s_tk[1:0], i_tx_bit_clock};
      s_rf <= {s_rf[1:0], i_rx_frame_sync};
      s_tf <= {s_tf[1:0], i_tx_frame_sync};
      s_rd <= {s_rd[1:0], i_rx_serial_in};
      rk_q <= agree(s_rk, rk_q);
      tk_q <= agree(s_tk, tk_q);
      rf_q <= agree(s_rf, rf_q);
      tf_q <= agree(s_tf, tf_q);
      rd_q <= agree(s_rd, rd_q);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Direction engines, index 0 rx, 1 tx
  logic [1:0] ext_ck;
  logic [1:0] ext_ck_d;
  logic [1:0] ext_fs;
  logic [1:0] fs_d;
  logic [1:0] bit_tick;
  logic [1:0] start_evt;
  logic [1:0] done;
  logic [1:0] busy;
  ssal_word_type sh [2];
  logic [1:0] tx_load;
  logic [1:0] fs_out;
  assign ext_ck = {tk_q, rk_q};
  assign ext_fs = {tf_q, rf_q};
  function automatic logic start_hit(input logic [2:0] sel, input logic fs,
                                     input logic fsd);
    case (sel)
      `SSAL_ST_AUTO: start_hit = 1'b1;
      `SSAL_ST_FALL: start_hit = fsd & ~fs;
      `SSAL_ST_RISE: start_hit = ~fsd & fs;
      `SSAL_ST_LOW: start_hit = ~fs;
      `SSAL_ST_HIGH: start_hit = fs;
      `SSAL_ST_ANY: start_hit = fsd ^ fs;
      default: start_hit = 1'b0;
    endcase
  endfunction : start_hit
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dir
      logic [15:0] md;
      logic en;
      ssal_state_type st;
      ssal_state_type next_st;
      logic [`SSAL_LEN_W-1:0] cnt;
      logic [`SSAL_LEN_W-1:0] next_cnt;
      ssal_word_type next_sh;
      logic next_fs;
      assign md = (g == 0) ? rxmode : txmode;
      assign en = ctrl[g] & i_pclk_en;
      assign bit_tick[g] = md[`SSAL_MODE_CKS] ? (ext_ck[g] & ~ext_ck_d[g]) : drise;
      assign start_evt[g] = start_hit(md[`SSAL_MODE_START_HI:`SSAL_MODE_START_LO],
                                      ext_fs[g], fs_d[g]);
      assign busy[g] = (st == SSAL_SHIFT);
      assign done[g] = busy[g] & bit_tick[g] & (cnt == md[`SSAL_MODE_LEN_HI:`SSAL_MODE_LEN_LO]);
      // Frames open on a bit tick, so bit 0 lasts a full period
      assign tx_load[g] = (st == SSAL_WAIT) & start_evt[g] & bit_tick[g] &
                          ((g == 0) | thr_full);
      always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_sh = sh[g];
        next_fs = 1'b0;
        case (st)
          SSAL_IDLE: begin
            if (en) begin
              next_st = SSAL_WAIT;
            end
          end
          SSAL_WAIT: begin
            if (!en) begin
              next_st = SSAL_IDLE;
            end else if (tx_load[g]) begin
              next_st = SSAL_SHIFT;
              next_cnt = '0;
              next_fs = 1'b1;
              next_sh = (g == 1) ? thr : `SSAL_ZERO32;
            end
          end
          SSAL_SHIFT: begin
            next_fs = 1'b1;
            if (!en) begin
              next_st = SSAL_IDLE;
            end else if (bit_tick[g]) begin
              next_cnt = cnt + 1'b1;
              if (g == 0) begin
                next_sh = {rd_q, sh[g][`SSAL_WORD_W-1:1]};
              end else begin
                next_sh = {1'b0, sh[g][`SSAL_WORD_W-1:1]};
              end
              if (done[g]) begin
                next_st = SSAL_WAIT;
                next_fs = 1'b0;
              end
            end
          end
          default: next_st = SSAL_IDLE;
        endcase
      end
      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          st <= SSAL_IDLE;
          cnt <= '0;
          sh[g] <= `SSAL_ZERO32;
          fs_out[g] <= 1'b0;
          ext_ck_d[g] <= 1'b0;
          fs_d[g] <= 1'b0;
        end else begin
          st <= next_st;
          cnt <= next_cnt;
          sh[g] <= next_sh;
          fs_out[g] <= next_fs;
          ext_ck_d[g] <= ext_ck[g];
          fs_d[g] <= ext_fs[g];
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////
  // APB slave, holding registers and flags
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] next_prdata;
  logic [`SSAL_NEVT-1:0] set_ev;
  logic [`SSAL_NEVT-1:0] next_stat;
  logic next_thr_full;
  ssal_word_type next_rhr;
  ssal_word_type rx_word;
  logic rhr_full;
  logic next_rhr_full;
  logic hit;
  assign acc = i_psel & i_penable & o_pready & i_pclk_en;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  // Received word with its last bit, right aligned to its length
  assign rx_word = {rd_q, sh[0][`SSAL_WORD_W-1:1]} >>
    (`SSAL_LEN_W'(`SSAL_WORD_W - 1) - rxmode[`SSAL_MODE_LEN_HI:`SSAL_MODE_LEN_LO]);
  always_comb begin
    set_ev = '0;
    next_thr_full = thr_full;
    next_rhr = rhr;
    next_rhr_full = rhr_full;
    if (tx_load[1]) begin
      next_thr_full = 1'b0;
      set_ev[`SSAL_EV_TXFREE] = 1'b1;
    end
    if (wr && i_paddr == `SSAL_OFF_THR) begin
      next_thr_full = 1'b1;
    end
    if (done[1] && !next_thr_full) begin
      set_ev[`SSAL_EV_TX_ALL_EMPTY] = 1'b1;
    end
    if (rd && i_paddr == `SSAL_OFF_RHR) begin
      next_rhr_full = 1'b0;
    end
    if (done[0]) begin
      next_rhr = rx_word;
      next_rhr_full = 1'b1;
      set_ev[`SSAL_EV_RXAVAIL] = 1'b1;
      set_ev[`SSAL_EV_RXOVR] = rhr_full;
    end
    // Sticky, write one clears, set wins
    next_stat = stat;
    if (wr && i_paddr == `SSAL_OFF_STAT) begin
      next_stat = stat & ~i_pwdata[`SSAL_NEVT-1:0];
    end
    next_stat = next_stat | set_ev;
    hit = 1'b1;
    next_prdata = `SSAL_ZERO32;
    case (i_paddr)
      `SSAL_OFF_CTRL: next_prdata = {30'h0000_0000, ctrl};
      `SSAL_OFF_DIV: next_prdata = {20'h0_0000, div};
      `SSAL_OFF_TXMODE: next_prdata = {16'h0000, txmode};
      `SSAL_OFF_RXMODE: next_prdata = {16'h0000, rxmode};
      `SSAL_OFF_THR: next_prdata = `SSAL_ZERO32;
      `SSAL_OFF_RHR: next_prdata = rhr;
      `SSAL_OFF_STAT: next_prdata = {28'h000_0000, stat};
      `SSAL_OFF_MASK: next_prdata = {28'h000_0000, mask};
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ctrl <= '0;
      div <= '0;
      txmode <= '0;
      rxmode <= '0;
      thr <= `SSAL_ZERO32;
      rhr <= `SSAL_ZERO32;
      stat <= '0;
      mask <= '0;
      thr_full <= 1'b0;
      rhr_full <= 1'b0;
      o_prdata <= `SSAL_ZERO32;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_pclk_en) begin
      stat <= next_stat;
      thr_full <= next_thr_full;
      rhr <= next_rhr;
      rhr_full <= next_rhr_full;
      // One answer per request, also after a gated setup
      o_pready <= i_psel & ~o_pready;
      o_pslverr <= i_psel & ~o_pready & ~hit;
      o_prdata <= next_prdata;
      o_irq <= |(next_stat & mask);
      if (wr) begin
        case (i_paddr)
          `SSAL_OFF_CTRL: ctrl <= i_pwdata[1:0];
          `SSAL_OFF_DIV: div <= i_pwdata[`SSAL_DIV_W-1:0];
          `SSAL_OFF_TXMODE: txmode <= i_pwdata[15:0];
          `SSAL_OFF_RXMODE: rxmode <= i_pwdata[15:0];
          `SSAL_OFF_THR: thr <= i_pwdata;
          `SSAL_OFF_MASK: mask <= i_pwdata[`SSAL_NEVT-1:0];
          default: ;
        endcase
      end
    end else begin
      o_pready <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Pins and DMA
  // Three lines per direction, clocks and syncs two-way
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_tx_serial_out <= 1'b0;
      o_rx_bit_clock <= 1'b0;
      o_rx_bit_clock_oe <= 1'b0;
      o_tx_bit_clock <= 1'b0;
      o_tx_bit_clock_oe <= 1'b0;
      o_rx_frame_sync <= 1'b0;
      o_rx_frame_sync_oe <= 1'b0;
      o_tx_frame_sync <= 1'b0;
      o_tx_frame_sync_oe <= 1'b0;
      o_dma_tx_req <= 1'b0;
      o_dma_rx_req <= 1'b0;
    end else begin
      o_tx_serial_out <= sh[1][0] & busy[1];
      o_rx_bit_clock <= dclk;
      o_rx_bit_clock_oe <= rxmode[`SSAL_MODE_CKO] & ctrl[0];
      o_tx_bit_clock <= dclk;
      o_tx_bit_clock_oe <= txmode[`SSAL_MODE_CKO] & ctrl[1];
      o_rx_frame_sync <= fs_out[0];
      o_rx_frame_sync_oe <= rxmode[`SSAL_MODE_FSO];
      o_tx_frame_sync <= fs_out[1];
      o_tx_frame_sync_oe <= txmode[`SSAL_MODE_FSO];
      // Request while word wanted or waiting
      o_dma_tx_req <= ctrl[1] & ~next_thr_full;
      o_dma_rx_req <= ctrl[0] & next_rhr_full;
    end
  end
  // Assertions
  sequence s_rx_done;
    done[0] && i_pclk_en;
  endsequence
  a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    i_pclk_en |=> (o_irq == |($past(next_stat) & $past(mask))))
    else $error("irq does not follow status and mask");
  a_mask_blocks: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (mask == '0 && $stable(mask)) |=> !o_irq)
    else $error("masked event raised irq");
  a_rx_avail: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    s_rx_done |=> stat[`SSAL_EV_RXAVAIL] && rhr_full)
    else $error("rx word not posted");
  a_rx_overrun: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (s_rx_done ##0 rhr_full) |=> stat[`SSAL_EV_RXOVR])
    else $error("overrun not flagged");
  a_tx_free: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (tx_load[1] && i_pclk_en) |=> stat[`SSAL_EV_TXFREE] && busy[1])
    else $error("tx load not flagged");
  a_tx_empty: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (done[1] && !next_thr_full && i_pclk_en) |=> stat[`SSAL_EV_TX_ALL_EMPTY])
    else $error("tx empty not flagged");
  a_gate_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_pclk_en |=> $stable(stat) && $stable(thr_full))
    else $error("activity while gated");
  a_tx_auto: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (g_dir[1].st == SSAL_WAIT && thr_full && ctrl[1] && i_pclk_en && bit_tick[1] &&
     txmode[`SSAL_MODE_START_HI:`SSAL_MODE_START_LO] == `SSAL_ST_AUTO) |=> busy[1])
    else $error("auto start missed");
  a_apb_ready: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_psel && !i_penable && i_pclk_en) |=> o_pready)
    else $error("apb no answer");
endmodule : ssal_top
`default_nettype wire

// ==== pkg/ssal_cfg.svh ====
// Purpose: Offsets, fields and reset values of the serial audio link
// Assumes: APB with 32-bit data, byte addresses
// Notes: Included by the package and by the design files
`ifndef SSAL_CFG_SVH
`define SSAL_CFG_SVH
`define SSAL_OFF_CTRL 12'h000
`define SSAL_OFF_DIV 12'h004
`define SSAL_OFF_TXMODE 12'h008
`define SSAL_OFF_RXMODE 12'h00C
`define SSAL_OFF_THR 12'h010
`define SSAL_OFF_RHR 12'h014
`define SSAL_OFF_STAT 12'h018
`define SSAL_OFF_MASK 12'h01C
`define SSAL_DIV_W 12
`define SSAL_WORD_W 32
`define SSAL_LEN_W 5
`define SSAL_NEVT 4
`define SSAL_EV_TXFREE 0
`define SSAL_EV_TX_ALL_EMPTY 1
`define SSAL_EV_RXAVAIL 2
`define SSAL_EV_RXOVR 3
`define SSAL_CTRL_RXEN 0
`define SSAL_CTRL_TXEN 1
`define SSAL_MODE_START_LO 0
`define SSAL_MODE_START_HI 2
`define SSAL_MODE_CKS 3
`define SSAL_MODE_CKO 4
`define SSAL_MODE_FSO 5
`define SSAL_MODE_LEN_LO 8
`define SSAL_MODE_LEN_HI 12
`define SSAL_ST_AUTO 3'h0
`define SSAL_ST_FALL 3'h1
`define SSAL_ST_RISE 3'h2
`define SSAL_ST_LOW 3'h3
`define SSAL_ST_HIGH 3'h4
`define SSAL_ST_ANY 3'h5
`define SSAL_ZERO32 32'h0000_0000
`endif

// ==== pkg/ssal_pkg.sv ====
// Purpose: Types of the serial audio link
// Assumes: ssal_cfg.svh holds all numbers
// Notes: Shift state shared by both directions
`include "ssal_cfg.svh"
package ssal_pkg;
  typedef enum logic [2:0] {
    SSAL_IDLE = 3'b001,
    SSAL_WAIT = 3'b010,
    SSAL_SHIFT = 3'b100
  } ssal_state_type;
  typedef logic [`SSAL_WORD_W-1:0] ssal_word_type;
endpackage : ssal_pkg

// ==== hw/ssal_div.sv ====
// Purpose: Shared divider, mclk over 2N with equal levels
// Assumes: Divisor stable while running
// Notes: Zero divisor holds the output low
`timescale 1ns/100ps
`default_nettype none
`include "ssal_cfg.svh"
module ssal_div
  import ssal_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Divisor
  input wire logic [`SSAL_DIV_W-1:0] i_div,
  // Divided clock and its edges
  output logic o_clk,
  output logic o_rise,
  output logic o_fall
);
  logic [`SSAL_DIV_W-1:0] cnt;
  logic [`SSAL_DIV_W-1:0] next_cnt;
  logic next_clk;
  logic next_rise;
  logic next_fall;
  always_comb begin
    next_cnt = cnt;
    next_clk = o_clk;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (i_div == '0) begin
      next_cnt = '0;
      next_clk = 1'b0;
    end else if (cnt >= i_div - 1'b1) begin
      next_cnt = '0;
      next_clk = ~o_clk;
      next_rise = ~o_clk;
      next_fall = o_clk;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt <= '0;
      o_clk <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_clk <= next_clk;
      o_rise <= next_rise;
      o_fall <= next_fall;
    end
  end
  a_div_half: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_div == 12'h001 && $stable(i_div) && o_rise) |=> o_fall)
    else $error("divider half period wrong");
  a_div_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_div == '0) |=> !o_clk)
    else $error("divider runs at zero");
endmodule : ssal_div
`default_nettype wire

// ==== testbench/ssal_codec_model.sv ====
// Purpose: Far-side codec, captures tx words and serves rx words
// Assumes: Device drives bit clocks and frame syncs, data changes mid-bit
// Notes: Bits LSB first, LEN bits a word
`timescale 1ns/100ps
`default_nettype none
module ssal_codec_model #(
  parameter int LEN = 8
) (
  // Clock
  input wire logic i_mclk,
  // Transmit side of the device
  input wire logic i_tx_bclk,
  input wire logic i_tx_fs,
  input wire logic i_tx_data,
  // Receive side of the device
  input wire logic i_rx_bclk,
  input wire logic i_rx_fs,
  input wire logic [31:0] i_rx_word,
  output logic o_rx_data,
  // Captured words
  output logic o_cap_valid,
  output logic [31:0] o_cap_word
);
  logic tx_prev = 1'b0;
  logic rx_prev = 1'b0;
  int tbit = 0;
  int rbit = 0;
  logic [31:0] cap = 32'h0000_0000;
  initial o_rx_data = 1'b0;
  initial o_cap_valid = 1'b0;
  initial o_cap_word = 32'h0000_0000;
  always @(posedge i_mclk) begin
    o_cap_valid <= 1'b0;
    tx_prev <= i_tx_bclk;
    rx_prev <= i_rx_bclk;
    if (!i_tx_fs) begin
      tbit = 0;
    end else if (tx_prev && !i_tx_bclk) begin
      cap[tbit] = i_tx_data;
      if (tbit == LEN - 1) begin
        o_cap_word <= cap & ((32'h0000_0001 << LEN) - 1);
        o_cap_valid <= 1'b1;
        tbit = 0;
      end else begin
        tbit++;
      end
    end
    if (!i_rx_fs) begin
      rbit = 0;
      o_rx_data <= i_rx_word[0];
    end else if (rx_prev && !i_rx_bclk) begin
      o_rx_data <= i_rx_word[rbit];
      rbit = (rbit == LEN - 1) ? 0 : rbit + 1;
    end
  end
endmodule : ssal_codec_model
`default_nettype wire

// ==== testbench/ssal_top_tb.sv ====
// Purpose: Self-checking bench of the serial audio link
// Assumes: Codec model on the pins, APB master here
// Notes: Expected results queued, checked by monitors
`timescale 1ns/100ps
`default_nettype none
`include "ssal_cfg.svh"
module ssal_top_tb;
  import ssal_pkg::*;
  logic i_mclk, i_rstn, i_pclk_en, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rx_word, rng, cap_word;
  logic o_pready, o_pslverr, rx_data, o_rx_bclk, o_rx_bclk_oe, o_rx_fs, o_rx_fs_oe;
  logic o_tx_data, o_tx_bclk, o_tx_bclk_oe, o_tx_fs, o_tx_fs_oe;
  logic o_dma_tx_req, o_dma_rx_req, o_irq, cap_valid;
  logic rx_bclk_pin, rx_fs_pin, tx_bclk_pin, tx_fs_pin;
  logic [64:0] apb_q[$];
  logic [31:0] tx_q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int w, h, l;
  int nv [3] = '{1, 3, 8};
  // Pin levels from the enables
  assign rx_bclk_pin = o_rx_bclk_oe ? o_rx_bclk : 1'b0;
  assign rx_fs_pin = o_rx_fs_oe ? o_rx_fs : 1'b0;
  assign tx_bclk_pin = o_tx_bclk_oe ? o_tx_bclk : 1'b0;
  assign tx_fs_pin = o_tx_fs_oe ? o_tx_fs : 1'b0;
  always #5 i_mclk = ~i_mclk;
  ssal_top u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_pclk_en(i_pclk_en), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_rx_serial_in(rx_data), .i_rx_bit_clock(rx_bclk_pin), .o_rx_bit_clock(o_rx_bclk),
    .o_rx_bit_clock_oe(o_rx_bclk_oe), .i_rx_frame_sync(rx_fs_pin),
    .o_rx_frame_sync(o_rx_fs), .o_rx_frame_sync_oe(o_rx_fs_oe), .o_tx_serial_out(o_tx_data),
    .i_tx_bit_clock(tx_bclk_pin), .o_tx_bit_clock(o_tx_bclk), .o_tx_bit_clock_oe(o_tx_bclk_oe),
    .i_tx_frame_sync(tx_fs_pin), .o_tx_frame_sync(o_tx_fs), .o_tx_frame_sync_oe(o_tx_fs_oe),
    .o_dma_tx_req(o_dma_tx_req), .o_dma_rx_req(o_dma_rx_req), .o_irq(o_irq));
  ssal_codec_model #(.LEN(8)) u_codec (.i_mclk(i_mclk), .i_tx_bclk(tx_bclk_pin),
    .i_tx_fs(tx_fs_pin), .i_tx_data(o_tx_data), .i_rx_bclk(rx_bclk_pin), .i_rx_fs(rx_fs_pin),
    .i_rx_word(rx_word), .o_rx_data(rx_data), .o_cap_valid(cap_valid), .o_cap_word(cap_word));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // One APB transfer, expectation {err, mask, data} queued
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [64:0] e);
    @(posedge i_mclk);
    apb_q.push_back(e);
    w = 0;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    @(posedge i_mclk);
    while (o_pready !== 1'b1) begin
      @(posedge i_mclk);
      w++;
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 64'h0000_0000_0000_0000});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic err);
    apb(1'b0, a, 32'h0000_0000, {err, m, e});
  endtask : rd
  task automatic wait_hi(input string nm, ref logic s, input int lim);
    int c;
    c = 0;
    while (s !== 1'b1 && c < lim) begin
      @(posedge i_mclk);
      c++;
    end
    chk(nm, 32'h0000_0001, {31'h0, s});
  endtask : wait_hi
  task automatic meas;
    repeat (2) begin
      wait_hi("bit clock", o_tx_bclk, 100);
      h = 0;
      while (o_tx_bclk === 1'b1 && h < 100) begin
        @(posedge i_mclk);
        h++;
      end
      l = 0;
      while (o_tx_bclk === 1'b0 && l < 100) begin
        @(posedge i_mclk);
        l++;
      end
    end
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////
  // Monitors
  always @(posedge i_mclk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      if (apb_q.size() != 0) begin
        logic [64:0] e;
        e = apb_q.pop_front();
        chk("apb data", e[31:0], o_prdata & e[63:32]);
        chk("apb error", {31'h0, e[64]}, {31'h0, o_pslverr});
      end
    end
    if (cap_valid === 1'b1 && tx_q.size() != 0) begin
      chk("tx word", tx_q.pop_front(), cap_word);
    end
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    $display("Error watchdog expected finish seen hang");
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    i_rstn = 1'b0;
    i_pclk_en = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    rng = 32'h0000_6D02;
    rx_word = 32'h0000_0000;
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(`SSAL_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
    wr(`SSAL_OFF_DIV, 32'hFFFF_FFFF, 1'b0);
    rd(`SSAL_OFF_DIV, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'b0);
    wr(12'h020, 32'h0000_00FF, 1'b1);
    rd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    for (int s = 0; s < 6; s++) begin
      wr(`SSAL_OFF_RXMODE, 32'h0000_0730 | s, 1'b0);
      rd(`SSAL_OFF_RXMODE, 32'hFFFF_FFFF, 32'h0000_0730 | s, 1'b0);
    end
    wr(`SSAL_OFF_TXMODE, 32'h0000_0730, 1'b0);
    wr(`SSAL_OFF_CTRL, 32'h0000_0002, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(`SSAL_OFF_DIV, nv[i], 1'b0);
      meas();
      chk("divider high", nv[i], h);
      chk("divider low", nv[i], l);
    end
    wr(`SSAL_OFF_DIV, 32'h0000_0000, 1'b0);
    repeat (20) @(posedge i_mclk);
    h = 0;
    repeat (40) begin
      @(posedge i_mclk);
      if (o_tx_bclk !== 1'b0) h++;
    end
    chk("divider off", 32'd0, h);
    wr(`SSAL_OFF_DIV, 32'h0000_0008, 1'b0);
    wr(`SSAL_OFF_MASK, 32'h0000_0000, 1'b0);
    chk("tx dma request", 32'h1, {31'h0, o_dma_tx_req});
    chk("pin enables", 32'h3, {30'h0, o_tx_bclk_oe, o_tx_fs_oe});
    repeat (2) begin
      rng = xs(rng);
      tx_q.push_back(rng & 32'h0000_00FF);
      wr(`SSAL_OFF_THR, rng & 32'h0000_00FF, 1'b0);
    end
    w = 0;
    while (tx_q.size() != 0 && w < 3000) begin
      @(posedge i_mclk);
      w++;
    end
    chk("tx words left", 32'd0, tx_q.size());
    repeat (40) @(posedge i_mclk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    rd(`SSAL_OFF_STAT, 32'h0000_000F, 32'h0000_0003, 1'b0);
    wr(`SSAL_OFF_MASK, 32'h0000_0002, 1'b0);
    repeat (3) @(posedge i_mclk);
    chk("irq unmasked", 32'h1, {31'h0, o_irq});
    wr(`SSAL_OFF_STAT, 32'h0000_0003, 1'b0);
    rd(`SSAL_OFF_STAT, 32'h0000_0003, 32'h0000_0000, 1'b0);
    repeat (3) @(posedge i_mclk);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    rng = xs(rng);
    rx_word = rng & 32'h0000_00FF;
    wr(`SSAL_OFF_RXMODE, 32'h0000_0730, 1'b0);
    wr(`SSAL_OFF_CTRL, 32'h0000_0003, 1'b0);
    wait_hi("rx dma request", o_dma_rx_req, 2000);
    rd(`SSAL_OFF_RHR, 32'hFFFF_FFFF, rx_word, 1'b0);
    wr(`SSAL_OFF_MASK, 32'h0000_0008, 1'b0);
    wait_hi("overrun irq", o_irq, 2000);
    rd(`SSAL_OFF_STAT, 32'h0000_000C, 32'h0000_000C, 1'b0);
    rd(`SSAL_OFF_RHR, 32'hFFFF_FFFF, rx_word, 1'b0);
    i_pclk_en <= 1'b0;
    fork
      begin
        repeat (20) @(posedge i_mclk);
        i_pclk_en <= 1'b1;
      end
      rd(`SSAL_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0003, 1'b0);
    join
    chk("gated wait", 32'h1, {31'h0, w >= 17});
    final_report();
  end
endmodule : ssal_top_tb
`default_nettype wire
